/* File: logic/his_top.sv */
// Host interface select: latches the select pin at startup and routes the shared pads.
//
// Functional notes
// RQ1: Sample the select pin at startup; its level picks the pad function group.
// RQ2: Select high or open routes pads to the serial port and I2C slave.
// RQ3: Select low routes the pads to the SPI slave port.
// RQ4: SPI stays off by default since its pads belong to serial and I2C.
// RQ5: In SPI mode the I2C slave sees idle lines and is disabled.
// RQ6: SPI is slave only; host keeps SPI clock at or below 5.5 MHz.
// RQ7: I2C port is slave only: never drives the clock, only pulls data low.
// RQ8: Host keeps the I2C clock at or below 400 kHz.
// RQ9: Every selected interface carries the same message byte streams unchanged.
// RQ10: Selection is latched once per reset; later select pin changes are ignored.
`timescale 1ns/10ps
`include "his_cfg.svh"
module his_top (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sel_pin,
   input wire logic pad15_in,
   output logic pad16_out,
   output logic pad16_oe,
   input wire logic pad29_in,
   output logic pad29_out,
   output logic pad29_oe,
   input wire logic pad30_in,
   output logic pad30_out,
   output logic pad30_oe,
   input wire logic uart_txd,
   output logic uart_rxd,
   output logic uart_en,
   output logic i2c_scl,
   output logic i2c_sda,
   input wire logic i2c_sda_pull_low,
   output logic i2c_en,
   input wire logic spi_miso,
   output logic spi_mosi,
   output logic spi_sclk,
   output logic spi_sclk_rise,
   output logic spi_sclk_fall,
   output logic spi_cs_n,
   output logic spi_en,
   output logic mode_valid
);

   // ============================================================
   // Pad input synchronisation
   // ============================================================
   logic [`HIS_SYNC_W-1:0] pad_async;
   logic [`HIS_SYNC_W-1:0] pad_sync;

   assign pad_async[`HIS_BIT_SEL] = sel_pin;
   assign pad_async[`HIS_BIT_PAD15] = pad15_in;
   assign pad_async[`HIS_BIT_PAD29] = pad29_in;
   assign pad_async[`HIS_BIT_PAD30] = pad30_in;

   his_sync #(
      .W(`HIS_SYNC_W)
   ) u_sync (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .async_in(pad_async),
      .sync_out(pad_sync)
   );

   // ============================================================
   // Startup sequencer and mode latch
   // ============================================================
   his_pkg::his_state_t state_q;
   his_pkg::his_state_t state_d;
   his_pkg::his_mode_t mode_q;
   his_pkg::his_mode_t mode_d;
   logic [`HIS_CNT_W-1:0] cnt_q;
   logic [`HIS_CNT_W-1:0] cnt_d;

   always_comb begin
      state_d = state_q;
      mode_d = mode_q;
      cnt_d = cnt_q;
      case (state_q)
         his_pkg::HIS_ST_IDLE: begin
            cnt_d = '0;
            state_d = his_pkg::HIS_ST_SETTLE;
         end
         his_pkg::HIS_ST_SETTLE: begin
            // The wait lets the synchroniser fill with real pad levels first.
            if (cnt_q == `HIS_CNT_W'(`HIS_SETTLE_CYC - 1)) begin
               if (pad_sync[`HIS_BIT_SEL] == `HIS_SEL_SPI) begin
                  mode_d = his_pkg::HIS_MODE_SPI; // RQ3
               end else begin
                  mode_d = his_pkg::HIS_MODE_UART_I2C; // RQ2
               end
               state_d = his_pkg::HIS_ST_RUN; // RQ1
            end else begin
               cnt_d = cnt_q + `HIS_CNT_W'(1);
            end
         end
         his_pkg::HIS_ST_RUN: begin
            // The select pin is no longer looked at until the next reset.
            mode_d = mode_q; // RQ10
         end
         default: begin
            state_d = his_pkg::HIS_ST_IDLE;
            mode_d = his_pkg::HIS_MODE_NONE;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= his_pkg::HIS_ST_IDLE;
         mode_q <= his_pkg::HIS_MODE_NONE;
         cnt_q <= '0;
      end else begin
         state_q <= state_d;
         mode_q <= mode_d;
         cnt_q <= cnt_d;
      end
   end

   // ============================================================
   // Pad routing
   // ============================================================
   logic sclk_prev_q;
   logic sclk_prev_d;
   logic pad16_out_q, pad16_out_d;
   logic pad16_oe_q, pad16_oe_d;
   logic pad29_out_q, pad29_out_d;
   logic pad29_oe_q, pad29_oe_d;
   logic pad30_out_q, pad30_out_d;
   logic pad30_oe_q, pad30_oe_d;
   logic uart_rxd_q, uart_rxd_d;
   logic uart_en_q, uart_en_d;
   logic i2c_scl_q, i2c_scl_d;
   logic i2c_sda_q, i2c_sda_d;
   logic i2c_en_q, i2c_en_d;
   logic spi_mosi_q, spi_mosi_d;
   logic spi_sclk_q, spi_sclk_d;
   logic spi_rise_q, spi_rise_d;
   logic spi_fall_q, spi_fall_d;
   logic spi_cs_n_q, spi_cs_n_d;
   logic spi_en_q, spi_en_d;
   logic mode_valid_q, mode_valid_d;

   always_comb begin
      // Safe idle values: no pad driven and every core sees an idle line.
      pad16_out_d = `HIS_UART_IDLE;
      pad16_oe_d = 1'b0;
      pad29_out_d = 1'b0;
      pad29_oe_d = 1'b0; // RQ7
      pad30_out_d = 1'b0;
      pad30_oe_d = 1'b0;
      uart_rxd_d = `HIS_UART_IDLE;
      uart_en_d = 1'b0;
      i2c_scl_d = `HIS_I2C_IDLE;
      i2c_sda_d = `HIS_I2C_IDLE;
      i2c_en_d = 1'b0;
      spi_mosi_d = `HIS_SPI_DATA_IDLE;
      spi_sclk_d = `HIS_SPI_CLK_IDLE;
      spi_cs_n_d = `HIS_SPI_CS_IDLE;
      spi_en_d = 1'b0; // RQ4
      sclk_prev_d = `HIS_SPI_CLK_IDLE;
      spi_rise_d = 1'b0;
      spi_fall_d = 1'b0;
      mode_valid_d = (mode_q != his_pkg::HIS_MODE_NONE);
      case (mode_q)
         his_pkg::HIS_MODE_UART_I2C: begin
            pad16_out_d = uart_txd; // RQ9
            pad16_oe_d = 1'b1; // RQ2
            uart_rxd_d = pad_sync[`HIS_BIT_PAD15]; // RQ9
            uart_en_d = 1'b1; // RQ2
            i2c_scl_d = pad_sync[`HIS_BIT_PAD29]; // RQ7
            i2c_sda_d = pad_sync[`HIS_BIT_PAD30];
            pad30_oe_d = i2c_sda_pull_low; // RQ7
            i2c_en_d = 1'b1; // RQ2
         end
         his_pkg::HIS_MODE_SPI: begin
            spi_en_d = 1'b1; // RQ3
            spi_mosi_d = pad_sync[`HIS_BIT_PAD15]; // RQ9
            spi_sclk_d = pad_sync[`HIS_BIT_PAD29]; // RQ6
            spi_cs_n_d = pad_sync[`HIS_BIT_PAD30];
            sclk_prev_d = pad_sync[`HIS_BIT_PAD29];
            spi_rise_d = pad_sync[`HIS_BIT_PAD29] & ~sclk_prev_q;
            spi_fall_d = ~pad_sync[`HIS_BIT_PAD29] & sclk_prev_q;
            // As a slave the output pad is driven only while chip select is low.
            pad16_out_d = spi_miso;
            pad16_oe_d = ~pad_sync[`HIS_BIT_PAD30]; // RQ6
            i2c_en_d = 1'b0; // RQ5
         end
         default: begin
            mode_valid_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sclk_prev_q <= `HIS_SPI_CLK_IDLE;
         pad16_out_q <= `HIS_UART_IDLE;
         pad16_oe_q <= 1'b0;
         pad29_out_q <= 1'b0;
         pad29_oe_q <= 1'b0;
         pad30_out_q <= 1'b0;
         pad30_oe_q <= 1'b0;
         uart_rxd_q <= `HIS_UART_IDLE;
         uart_en_q <= 1'b0;
         i2c_scl_q <= `HIS_I2C_IDLE;
         i2c_sda_q <= `HIS_I2C_IDLE;
         i2c_en_q <= 1'b0;
         spi_mosi_q <= `HIS_SPI_DATA_IDLE;
         spi_sclk_q <= `HIS_SPI_CLK_IDLE;
         spi_rise_q <= 1'b0;
         spi_fall_q <= 1'b0;
         spi_cs_n_q <= `HIS_SPI_CS_IDLE;
         spi_en_q <= 1'b0;
         mode_valid_q <= 1'b0;
      end else begin
         sclk_prev_q <= sclk_prev_d;
         pad16_out_q <= pad16_out_d;
         pad16_oe_q <= pad16_oe_d;
         pad29_out_q <= pad29_out_d;
         pad29_oe_q <= pad29_oe_d;
         pad30_out_q <= pad30_out_d;
         pad30_oe_q <= pad30_oe_d;
         uart_rxd_q <= uart_rxd_d;
         uart_en_q <= uart_en_d;
         i2c_scl_q <= i2c_scl_d;
         i2c_sda_q <= i2c_sda_d;
         i2c_en_q <= i2c_en_d;
         spi_mosi_q <= spi_mosi_d;
         spi_sclk_q <= spi_sclk_d;
         spi_rise_q <= spi_rise_d;
         spi_fall_q <= spi_fall_d;
         spi_cs_n_q <= spi_cs_n_d;
         spi_en_q <= spi_en_d;
         mode_valid_q <= mode_valid_d;
      end
   end

   assign pad16_out = pad16_out_q;
   assign pad16_oe = pad16_oe_q;
   assign pad29_out = pad29_out_q;
   assign pad29_oe = pad29_oe_q;
   assign pad30_out = pad30_out_q;
   assign pad30_oe = pad30_oe_q;
   assign uart_rxd = uart_rxd_q;
   assign uart_en = uart_en_q;
   assign i2c_scl = i2c_scl_q;
   assign i2c_sda = i2c_sda_q;
   assign i2c_en = i2c_en_q;
   assign spi_mosi = spi_mosi_q;
   assign spi_sclk = spi_sclk_q;
   assign spi_sclk_rise = spi_rise_q;
   assign spi_sclk_fall = spi_fall_q;
   assign spi_cs_n = spi_cs_n_q;
   assign spi_en = spi_en_q;
   assign mode_valid = mode_valid_q;

endmodule

/* File: logic/his_cfg.svh */
// Timing counts, pin bit positions and reset values of the host interface select block.
`ifndef HIS_CFG_SVH
`define HIS_CFG_SVH

// ============================================================
// Clock and startup timing
// ============================================================
`define HIS_CLK_PERIOD_NS 10
`define HIS_SETTLE_NS 100
`define HIS_SETTLE_CYC ((`HIS_SETTLE_NS + `HIS_CLK_PERIOD_NS - 1) / `HIS_CLK_PERIOD_NS)
`define HIS_CNT_W 4

// ============================================================
// Host side limits, kept by the master
// ============================================================
`define HIS_SPI_SCLK_MAX_KHZ 5500
`define HIS_SPI_MAX_KBYTE_S 125
`define HIS_I2C_SCL_MAX_KHZ 400
`define HIS_I2C_MAX_KBIT_S 400

// ============================================================
// Synchronised pad inputs
// ============================================================
`define HIS_SYNC_W 4
`define HIS_BIT_SEL 0
`define HIS_BIT_PAD15 1
`define HIS_BIT_PAD29 2
`define HIS_BIT_PAD30 3

// ============================================================
// Select levels and idle values
// ============================================================
`define HIS_SEL_UART_I2C 1'b1
`define HIS_SEL_SPI 1'b0
`define HIS_UART_IDLE 1'b1
`define HIS_I2C_IDLE 1'b1
`define HIS_SPI_CS_IDLE 1'b1
`define HIS_SPI_CLK_IDLE 1'b0
`define HIS_SPI_DATA_IDLE 1'b0

`endif

/* File: logic/his_pkg.sv */
// Types shared by the host interface select block.
package his_pkg;

   typedef enum logic [2:0] {
      HIS_ST_IDLE = 3'h1,
      HIS_ST_SETTLE = 3'h2,
      HIS_ST_RUN = 3'h4
   } his_state_t;

   typedef enum logic [1:0] {
      HIS_MODE_NONE = 2'h0,
      HIS_MODE_UART_I2C = 2'h1,
      HIS_MODE_SPI = 2'h2
   } his_mode_t;

endpackage

/* File: logic/his_sync.sv */
// Two-stage synchroniser for pad inputs, one stage pair per bit.
`timescale 1ns/10ps
module his_sync #(
   parameter int W = 4
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic meta_q;
         logic meta_d;
         logic stab_q;
         logic stab_d;
         always_comb begin
            meta_d = async_in[i];
            stab_d = meta_q;
         end
         always_ff @(posedge core_clk) begin
            if (sys_rst) begin
               meta_q <= 1'b1;
               stab_q <= 1'b1;
            end else begin
               meta_q <= meta_d;
               stab_q <= stab_d;
            end
         end
         assign sync_out[i] = stab_q;
      end
   endgenerate

endmodule

/* File: verif/his_top_assertions.sv */
// Concurrent checks on the ports of the host interface select block.
`timescale 1ns/10ps
module his_top_assertions (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic pad15_in,
   input wire logic pad16_out,
   input wire logic pad16_oe,
   input wire logic pad29_in,
   input wire logic pad29_out,
   input wire logic pad29_oe,
   input wire logic pad30_in,
   input wire logic pad30_out,
   input wire logic pad30_oe,
   input wire logic uart_txd,
   input wire logic uart_rxd,
   input wire logic uart_en,
   input wire logic i2c_scl,
   input wire logic i2c_sda,
   input wire logic i2c_sda_pull_low,
   input wire logic i2c_en,
   input wire logic spi_sclk,
   input wire logic spi_sclk_rise,
   input wire logic spi_sclk_fall,
   input wire logic spi_cs_n,
   input wire logic spi_en,
   input wire logic mode_valid
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   // ============================================================
   // Mode selection
   // ============================================================
   AST_ONE_MODE: assert property (mode_valid |-> spi_en != i2c_en)
      else $error("modes not exclusive");
   AST_NO_DRIVE: assert property (!mode_valid |->
      !pad16_oe && !pad30_oe && !spi_en && !i2c_en)
      else $error("pad driven before mode latched");
   AST_LATCHED: assert property (mode_valid |=>
      mode_valid && $stable(spi_en) && $stable(i2c_en))
      else $error("mode changed after latch");
   AST_I2C_OFF: assert property (spi_en |->
      !i2c_en && !uart_en && i2c_scl && i2c_sda && !pad30_oe)
      else $error("i2c active in spi mode");
   AST_SPI_OFF: assert property (uart_en |->
      spi_cs_n && !spi_sclk && !spi_sclk_rise && !spi_sclk_fall)
      else $error("spi active in uart mode");
   // ============================================================
   // Pad routing
   // ============================================================
   AST_RXD: assert property (uart_en && $past(uart_en) |-> uart_rxd == $past(pad15_in, 3))
      else $error("rxd not routed");
   AST_TXD: assert property (uart_en && $past(uart_en) |->
      pad16_oe && pad16_out == $past(uart_txd))
      else $error("txd not routed");
   AST_SCLK: assert property (spi_en && $past(spi_en) |-> spi_sclk == $past(pad29_in, 3))
      else $error("spi clock not routed");
   AST_MISO_OE: assert property (spi_en && $past(spi_en, 3) |->
      pad16_oe == !$past(pad30_in, 3))
      else $error("miso enable wrong");
   AST_RISE: assert property (spi_sclk_rise |-> spi_sclk && !$past(spi_sclk))
      else $error("rise pulse misplaced");
   AST_FALL: assert property (spi_en && $past(spi_en) |->
      spi_sclk_fall == (!spi_sclk && $past(spi_sclk)))
      else $error("fall pulse misplaced");
   AST_SCL_FREE: assert property (!pad29_oe)
      else $error("clock pad driven");
   AST_OUT_LOW: assert property (!pad29_out && !pad30_out)
      else $error("pad level driven high");
   AST_SDA_OD: assert property (i2c_en && $past(i2c_en) |->
      pad30_oe == $past(i2c_sda_pull_low))
      else $error("sda pull wrong");
   cover property (spi_sclk_rise);
   cover property (spi_sclk_fall);
   cover property (i2c_en && pad30_oe);
   cover property ($rose(mode_valid) && spi_en);
endmodule
bind his_top his_top_assertions his_top_assertions_i (.core_clk, .sys_rst, .pad15_in,
   .pad16_out, .pad16_oe, .pad29_in, .pad29_out, .pad29_oe, .pad30_in, .pad30_out, .pad30_oe,
   .uart_txd, .uart_rxd, .uart_en, .i2c_scl, .i2c_sda, .i2c_sda_pull_low, .i2c_en, .spi_sclk,
   .spi_sclk_rise, .spi_sclk_fall, .spi_cs_n, .spi_en, .mode_valid);

/* File: verif/his_host.sv */
// Host processor model: SPI master, or UART sender and I2C bus holder.
`timescale 1ns/10ps
module his_host (
   input wire logic spi_mode,
   input wire logic go,
   input wire logic [7:0] tx_byte,
   input wire logic sda_low,
   input wire logic pad16_out,
   input wire logic pad16_oe,
   input wire logic pad30_oe,
   output logic pad15,
   output logic pad29,
   output logic pad30,
   output logic [7:0] rx_byte
);
   logic cs_n = 1'b1;
   logic sclk = 1'b0;
   logic mosi = 1'b0;
   logic line = 1'b1;
   logic toggle = 1'b0;
   // Released lines show a changing pattern rather than a held value.
   always #10 toggle = ~toggle;
   // SDA is open drain with a pull-up; SCL stands idle high.
   assign pad30 = spi_mode ? cs_n : !(sda_low || pad30_oe);
   assign pad29 = spi_mode ? sclk : 1'b1;
   assign pad15 = spi_mode ? (cs_n ? toggle : mosi) : line;
   always @(posedge go) begin
      if (spi_mode) begin
         cs_n = 1'b0;
         for (int i = 7; i >= 0; i--) begin
            mosi = tx_byte[i];
            // A 184 ns period keeps the clock under its ceiling.
            #92 sclk = 1'b1;
            rx_byte[i] = pad16_oe ? pad16_out : toggle;
            #92 sclk = 1'b0;
         end
         cs_n = 1'b1;
      end else begin
         for (int i = 0; i < 10; i++) begin
            line = (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : tx_byte[i-1];
            #160;
         end
      end
   end
endmodule

/* File: verif/host_interface_select_test.sv */
// Self-checking bench for the host interface select block.
`timescale 1ns/10ps
module host_interface_select_test;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic sel_pin = 1'b1;
   logic host_spi = 1'b0;
   logic uart_txd = 1'b1;
   logic i2c_sda_pull_low = 1'b0;
   logic spi_miso = 1'b0;
   logic go = 1'b0;
   logic host_sda_low = 1'b0;
   logic [7:0] tx_byte = 8'h00;
   logic [7:0] miso_byte = 8'h00;
   logic [7:0] got = 8'h00;
   logic [2:0] bit_n = 3'h0;
   logic [7:0] rx_byte;
   logic pad15_in, pad29_in, pad30_in, pad16_out, pad16_oe, pad30_oe, uart_rxd, uart_en;
   logic i2c_scl, i2c_sda, i2c_en, spi_mosi, spi_sclk, spi_sclk_rise, spi_cs_n, spi_en, mode_valid;
   int seed = 19;
   int n_errors = 0;
   int check_count = 0;
   his_top his_top_i (.core_clk, .sys_rst, .sel_pin, .pad15_in, .pad16_out, .pad16_oe,
      .pad29_in, .pad29_out(), .pad29_oe(), .pad30_in, .pad30_out(), .pad30_oe, .uart_txd,
      .uart_rxd, .uart_en, .i2c_scl, .i2c_sda, .i2c_sda_pull_low, .i2c_en, .spi_miso, .spi_mosi,
      .spi_sclk, .spi_sclk_rise, .spi_sclk_fall(), .spi_cs_n, .spi_en, .mode_valid);
   his_host his_host_i (.spi_mode(host_spi), .go, .tx_byte, .sda_low(host_sda_low), .pad16_out,
      .pad16_oe, .pad30_oe, .pad15(pad15_in), .pad29(pad29_in), .pad30(pad30_in), .rx_byte);
   initial forever #5 core_clk = ~core_clk;
   // The bench plays the internal cores: random UART and I2C bits, MISO bits MSB first.
   always @(posedge core_clk) begin
      uart_txd <= 1'($random(seed));
      i2c_sda_pull_low <= 1'($random(seed));
      if (spi_sclk_rise) begin
         got <= {got[6:0], spi_mosi};
         bit_n <= bit_n + 3'h1;
      end
      spi_miso <= miso_byte[3'h7 - bit_n];
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want);
      check_count++;
      if (seen !== want) begin
         n_errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   // Enable pattern {uart, i2c, spi} that each select level must give.
   function automatic logic [7:0] exp_modes(input logic sel);
      return {5'h00, sel, sel, ~sel};
   endfunction
   // Edges from reset release to mode_valid: leave idle, settle 10 cycles, register outputs.
   function automatic logic [7:0] exp_latch_edges();
      return 8'h01 + 8'h0a + 8'h01;
   endfunction
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wait_on(input bit uart, input logic lvl);
      int n;
      n = 0;
      while ((uart ? uart_rxd : spi_cs_n) !== lvl) begin
         tick(1);
         n++;
         if (n > 400) begin
            n_errors++;
            end_of_test();
         end
      end
   endtask
   task automatic startup(input logic sel);
      int n;
      sys_rst <= 1'b1;
      sel_pin <= sel;
      host_spi <= ~sel;
      tick(2);
      check({5'h00, pad16_oe, pad30_oe, mode_valid}, 8'h00);
      sys_rst <= 1'b0;
      n = 0;
      while (mode_valid !== 1'b1 && n < 40) begin
         tick(1);
         n++;
      end
      check(8'(n), exp_latch_edges());
      check({5'h00, uart_en, i2c_en, spi_en}, exp_modes(sel));
      sel_pin <= ~sel;
      tick(20);
      check({5'h00, uart_en, i2c_en, spi_en}, exp_modes(sel));
      sel_pin <= sel;
   endtask
   task automatic send(input logic spi);
      logic [7:0] u;
      tx_byte <= 8'($random(seed));
      miso_byte <= 8'($random(seed));
      go <= 1'b1;
      tick(1);
      go <= 1'b0;
      if (spi) begin
         wait_on(1'b0, 1'b0);
         wait_on(1'b0, 1'b1);
         tick(4);
         check(got, tx_byte);
         check(rx_byte, miso_byte);
      end else begin
         wait_on(1'b1, 1'b0);
         tick(8);
         for (int i = 0; i < 8; i++) begin
            tick(16);
            u = {uart_rxd, u[7:1]};
         end
         check(u, tx_byte);
         tick(30);
      end
   endtask
   initial begin
      // The select pin left open reads high through its pull-up.
      startup(1'b1);
      host_sda_low <= 1'b1;
      tick(5);
      check({4'h0, i2c_sda, i2c_scl, spi_cs_n, spi_sclk}, 8'h06);
      host_sda_low <= 1'b0;
      repeat (3) send(1'b0);
      startup(1'b0);
      check({5'h00, i2c_scl, i2c_sda, uart_en}, 8'h06);
      repeat (4) send(1'b1);
      end_of_test();
   end
endmodule
